// ==== hdl/rics_defines.svh ====
// Constants of the regulator configuration serial slave
// Functional notes
// - Slave only; the serial clock line is never driven by this block.
// - Data line is only pulled low or released; never driven high.
// - Port answers only while the supply is above the power-on threshold.
// - Transmitter changes the data line only while the clock is low.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Bytes are eight bits, MSB first, each followed by an acknowledge bit.
// - Each byte takes nine clocks; receiver pulls data low on the ninth.
// - Device answers to seven-bit address 1000_110 by acknowledging on ninth clock.
// - Control byte is seven address bits then direction: 0 write, 1 read.
// - On address mismatch or not ready the data line stays high: not-acknowledge.
// - After the control byte comes a register address byte, acknowledged if valid.
// - Register addresses 0, 1, 2 select north bridge, core and power-savings.
// - Single write: control, ack, register address, ack, data, ack, stop.
// - Written values take effect at the stop that ends the write.
// - Burst write fills successive registers; master may stop after second or third.
// - Two transactions only: register write and read from current address.
// - Offset code moves the regulator reference in 25 mV steps.
// - Each regulator register can raise power-good and overvoltage trip levels.
// - Power-savings register holds phase count, shed and restore spacing, offset keep.
// - Works at bus rates up to 100 kbit/s and 400 kbit/s.
// - Under power-on reset registers return to 00, 00 and 01.
// - Regulator register: bit 7 overvoltage boost, bit 6 power-good boost, 5:0 offset.
// - Read selects register by write then stop; master acks walk further registers.
`ifndef RICS_DEFINES_SVH
`define RICS_DEFINES_SVH

// Bus address and register map
`define RICS_DEV_ADDR        7'h46
`define RICS_REG_NB          8'h00
`define RICS_REG_CORE        8'h01
`define RICS_REG_PS          8'h02
`define RICS_REG_COUNT       8'h03

// Power-on values
`define RICS_RST_NB          8'h00
`define RICS_RST_CORE        8'h00
`define RICS_RST_PS          8'h01

// Regulator register fields
`define RICS_OVP_BIT         7
`define RICS_PG_BIT          6
`define RICS_OFS_MSB         5
`define RICS_OFFSET_STEP_MV  11'sh019

// Power-savings register fields
`define RICS_PS_PHASE_LSB    0
`define RICS_PS_SHED_LSB     2
`define RICS_PS_RESTORE_LSB  4
`define RICS_PS_KEEP_BIT     6

`endif

// ==== hdl/rics_pkg.sv ====
// Types of the regulator configuration serial slave
package rics_pkg;

  // Byte engine states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE    = 10'h001,
    ST_RX_CTL  = 10'h002,
    ST_ACK_CTL = 10'h004,
    ST_RX_REG  = 10'h008,
    ST_ACK_REG = 10'h010,
    ST_RX_DAT  = 10'h020,
    ST_ACK_DAT = 10'h040,
    ST_TX      = 10'h080,
    ST_RACK    = 10'h100,
    ST_IGNORE  = 10'h200
  } rics_state_t;

endpackage

// ==== hdl/rics_link_if.sv ====
// Bit handoff from the bus clock domain to the system domain
`timescale 1ns/10ps
interface rics_link_if;
  logic bit_tgl;
  logic bit_val;

  modport cap (output bit_tgl, output bit_val);
  modport eng (input bit_tgl, input bit_val);
endinterface

// ==== hdl/rics_sync.sv ====
// Two-flop level synchroniser
`timescale 1ns/10ps
module rics_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule

// ==== hdl/rics_bit_capture.sv ====
// Data bit capture on the bus clock's rising edge
`timescale 1ns/10ps
module rics_bit_capture (
  input  wire logic  i_scl_clk,
  input  wire logic  i_arst_n,
  input  wire logic  i_sda_in,
  rics_link_if.cap   lnk
);
  // Data is stable while the clock is high, so no sync here;
  // toggle marks a new bit for the system domain
  always_ff @(posedge i_scl_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lnk.bit_val <= 1'b0;
      lnk.bit_tgl <= 1'b0;
    end else begin
      lnk.bit_val <= i_sda_in;
      lnk.bit_tgl <= ~lnk.bit_tgl;
    end
  end
endmodule

// ==== hdl/rics_cfg_slave.sv ====
// Serial configuration slave with three regulator registers
`timescale 1ns/10ps
`include "rics_defines.svh"
module rics_cfg_slave #(
  parameter logic [6:0] DEV_ADDR = `RICS_DEV_ADDR
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_scl_clk,
  input  wire logic        i_sda_in,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  input  wire logic        i_por_ok,
  output logic [7:0]       o_north_bridge_offset_trip,
  output logic [7:0]       o_core_offset_trip,
  output logic [7:0]       o_power_savings_options,
  output logic             o_nb_overvoltage_trip_boost,
  output logic             o_nb_power_good_output_boost,
  output logic             o_core_overvoltage_trip_boost,
  output logic             o_core_power_good_output_boost,
  output logic signed [10:0] o_nb_offset_mv,
  output logic signed [10:0] o_core_offset_mv,
  output logic [1:0]       o_ps_phase_count,
  output logic [1:0]       o_ps_shed_cycles,
  output logic [1:0]       o_ps_restore_cycles,
  output logic             o_ps_core_offset_keep
);

  rics_link_if lnk ();
  // Checks run on the system clock and rest during reset
  default clocking cb_sys @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  rics_pkg::rics_state_t state;
  logic                  scl_s;
  logic                  sda_s;
  logic                  por_s;
  logic                  tgl_s;
  logic                  scl_q;
  logic                  sda_q;
  logic                  tgl_q;
  logic                  ev_start;
  logic                  ev_stop;
  logic                  ev_bit;
  logic                  ev_fall;
  logic [3:0]            cnt;
  logic [7:0]            sh;
  logic [7:0]            rx_byte;
  logic [7:0]            tx;
  logic                  rw;
  logic                  mack;
  logic [1:0]            ptr;
  logic                  ctl_hit;
  logic                  reg_ok;
  logic                  byte_done;
  logic [7:0]            cfg [3];
  logic [7:0]            shadow [3];
  logic [2:0]            pend;
  logic [7:0]            rd_cur;
  logic [7:0]            rd_nxt;

  // Read mux; past the third register reads as zero
  function automatic logic [7:0] rd_sel(input logic [1:0] p, input logic [7:0] r0,
                                        input logic [7:0] r1, input logic [7:0] r2);
    case (p)
      2'h0:    rd_sel = r0;
      2'h1:    rd_sel = r1;
      2'h2:    rd_sel = r2;
      default: rd_sel = 8'h00;
    endcase
  endfunction

  // Pointer step, saturates at the past-end value
  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = (p == 2'h3) ? 2'h3 : 2'(p + 2'h1);
  endfunction

  // Signed six-bit offset code to millivolts
  function automatic logic signed [10:0] offset_mv(input logic [5:0] c);
    logic signed [10:0] e;
    e = {{5{c[5]}}, c};
    offset_mv = e * `RICS_OFFSET_STEP_MV;
  endfunction

  // Bus clock domain: capture each bit on the rising edge
  rics_bit_capture u_cap (
    .i_scl_clk (i_scl_clk),
    .i_arst_n  (i_arst_n),
    .i_sda_in  (i_sda_in),
    .lnk       (lnk)
  );

  // Lines, supply flag and bit toggle into the system domain
  rics_sync #(.W(4)) u_sync (
    .i_clk    (i_sys_clk),
    .i_arst_n (i_arst_n),
    .i_d      ({i_scl_clk, i_sda_in, i_por_ok, lnk.bit_tgl}),
    .o_q      ({scl_s, sda_s, por_s, tgl_s})
  );

  // Delayed copies; reset low like the synchroniser, so no false edge
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      tgl_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      tgl_q <= tgl_s;
    end
  end

  // Bus events seen in the system domain
  assign ev_start = por_s & scl_s & scl_q & sda_q & ~sda_s;
  assign ev_stop  = scl_s & scl_q & ~sda_q & sda_s;
  assign ev_bit   = tgl_s ^ tgl_q;
  assign ev_fall  = scl_q & ~scl_s;

  // Byte assembly, MSB first
  assign rx_byte   = {sh[6:0], lnk.bit_val};
  assign ctl_hit   = (rx_byte[7:1] == DEV_ADDR);
  assign reg_ok    = (rx_byte < `RICS_REG_COUNT);
  assign byte_done = ev_bit && (cnt == 4'h7);
  assign rd_cur    = rd_sel(ptr, cfg[0], cfg[1], cfg[2]);
  assign rd_nxt    = rd_sel(ptr_inc(ptr), cfg[0], cfg[1], cfg[2]);

  // Open drain: output level is always low
  assign o_sda_out = 1'b0;

  // Byte engine; acks and data change only after a falling clock
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state    <= rics_pkg::ST_IDLE;
      cnt      <= 4'h0;
      sh       <= 8'h00;
      tx       <= 8'h00;
      rw       <= 1'b0;
      mack     <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (!por_s) begin
      state    <= rics_pkg::ST_IDLE;
      cnt      <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (ev_start) begin
      state    <= rics_pkg::ST_RX_CTL;
      cnt      <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (ev_stop) begin
      state    <= rics_pkg::ST_IDLE;
      cnt      <= 4'h0;
      o_sda_oe <= 1'b0;
    end else begin
      case (state)
        rics_pkg::ST_RX_CTL, rics_pkg::ST_RX_REG, rics_pkg::ST_RX_DAT: begin
          if (ev_bit) begin
            sh  <= rx_byte;
            cnt <= 4'(cnt + 4'h1);
          end
          if (byte_done) begin
            cnt <= 4'h0;
            if (state == rics_pkg::ST_RX_CTL) begin
              rw    <= rx_byte[0];
              state <= ctl_hit ? rics_pkg::ST_ACK_CTL : rics_pkg::ST_IGNORE;
            end else if (state == rics_pkg::ST_RX_REG) begin
              state <= reg_ok ? rics_pkg::ST_ACK_REG : rics_pkg::ST_IGNORE;
            end else begin
              state <= (ptr != 2'h3) ? rics_pkg::ST_ACK_DAT : rics_pkg::ST_IGNORE;
            end
          end
        end
        rics_pkg::ST_ACK_CTL, rics_pkg::ST_ACK_REG, rics_pkg::ST_ACK_DAT: begin
          if (ev_bit) begin
            cnt <= 4'h1;
          end
          if (ev_fall) begin
            if (cnt == 4'h0) begin
              o_sda_oe <= 1'b1;
            end else begin
              cnt      <= 4'h0;
              o_sda_oe <= 1'b0;
              if (state == rics_pkg::ST_ACK_CTL && rw) begin
                tx       <= rd_cur;
                o_sda_oe <= ~rd_cur[7];
                state    <= rics_pkg::ST_TX;
              end else if (state == rics_pkg::ST_ACK_CTL) begin
                state <= rics_pkg::ST_RX_REG;
              end else begin
                state <= rics_pkg::ST_RX_DAT;
              end
            end
          end
        end
        rics_pkg::ST_TX: begin
          if (ev_bit) begin
            cnt <= 4'(cnt + 4'h1);
          end
          if (ev_fall) begin
            if (cnt == 4'h8) begin
              cnt      <= 4'h0;
              o_sda_oe <= 1'b0; // Release for the master's ack
              state    <= rics_pkg::ST_RACK;
            end else begin
              tx       <= {tx[6:0], 1'b0};
              o_sda_oe <= ~tx[6];
            end
          end
        end
        rics_pkg::ST_RACK: begin
          if (ev_bit) begin
            cnt  <= 4'h1;
            mack <= ~lnk.bit_val;
          end
          if (ev_fall && cnt != 4'h0) begin
            cnt <= 4'h0;
            if (mack) begin
              tx       <= rd_nxt;
              o_sda_oe <= ~rd_nxt[7];
              state    <= rics_pkg::ST_TX;
            end else begin
              state <= rics_pkg::ST_IGNORE; // Not-ack ends the read
            end
          end
        end
        rics_pkg::ST_IDLE, rics_pkg::ST_IGNORE: begin
          o_sda_oe <= 1'b0;
        end
        default: begin
          state    <= rics_pkg::ST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Register pointer; kept across stop so a read follows the selection
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr <= 2'h0;
    end else if (!por_s) begin
      ptr <= 2'h0;
    end else if (!ev_start && !ev_stop) begin
      if (state == rics_pkg::ST_RX_REG && byte_done && reg_ok) begin
        ptr <= rx_byte[1:0];
      end else if (state == rics_pkg::ST_ACK_DAT && ev_fall && cnt != 4'h0) begin
        ptr <= ptr_inc(ptr);
      end else if (state == rics_pkg::ST_RACK && ev_fall && cnt != 4'h0 && mack) begin
        ptr <= ptr_inc(ptr);
      end
    end
  end

  // Staged write data; committed only at stop so a burst lands at once
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shadow <= '{8'h00, 8'h00, 8'h00};
      pend   <= 3'h0;
    end else if (!por_s || ev_start || ev_stop) begin
      pend <= 3'h0; // Unfinished writes die with a restart
    end else if (state == rics_pkg::ST_RX_DAT && byte_done && ptr != 2'h3) begin
      shadow[ptr] <= rx_byte;
      pend[ptr]   <= 1'b1;
    end
  end

  // Live registers seen by the regulator
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg <= '{`RICS_RST_NB, `RICS_RST_CORE, `RICS_RST_PS};
    end else if (!por_s) begin
      cfg <= '{`RICS_RST_NB, `RICS_RST_CORE, `RICS_RST_PS};
    end else if (ev_stop) begin
      for (int i = 0; i < 3; i++) begin
        if (pend[i]) begin
          cfg[i] <= shadow[i];
        end
      end
    end
  end

  // Field outputs straight from the live registers
  assign o_north_bridge_offset_trip     = cfg[0];
  assign o_core_offset_trip             = cfg[1];
  assign o_power_savings_options        = cfg[2];
  assign o_nb_overvoltage_trip_boost    = cfg[0][`RICS_OVP_BIT];
  assign o_nb_power_good_output_boost   = cfg[0][`RICS_PG_BIT];
  assign o_core_overvoltage_trip_boost  = cfg[1][`RICS_OVP_BIT];
  assign o_core_power_good_output_boost = cfg[1][`RICS_PG_BIT];
  assign o_ps_phase_count    = cfg[2][`RICS_PS_PHASE_LSB +: 2];
  assign o_ps_shed_cycles    = cfg[2][`RICS_PS_SHED_LSB +: 2];
  assign o_ps_restore_cycles = cfg[2][`RICS_PS_RESTORE_LSB +: 2];
  assign o_ps_core_offset_keep = cfg[2][`RICS_PS_KEEP_BIT];

  // Offset in millivolts, one cycle behind the register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_nb_offset_mv   <= 11'sh000;
      o_core_offset_mv <= 11'sh000;
    end else begin
      o_nb_offset_mv   <= offset_mv(cfg[0][`RICS_OFS_MSB:0]);
      o_core_offset_mv <= offset_mv(cfg[1][`RICS_OFS_MSB:0]);
    end
  end

  // Checks
  sequence s_ctl_hit;
    state == rics_pkg::ST_RX_CTL && byte_done && ctl_hit && por_s && !ev_start && !ev_stop;
  endsequence
  sequence s_ctl_miss;
    state == rics_pkg::ST_RX_CTL && byte_done && !ctl_hit && por_s && !ev_start && !ev_stop;
  endsequence
  sequence s_ack_start;
    (state == rics_pkg::ST_ACK_CTL || state == rics_pkg::ST_ACK_REG ||
     state == rics_pkg::ST_ACK_DAT) && ev_fall && cnt == 4'h0 && por_s &&
    !ev_start && !ev_stop;
  endsequence

  property p_sda_low_only;
    o_sda_out == 1'b0;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("data line driven high");
  property p_por_quiet;
    !por_s |=> !o_sda_oe && state == rics_pkg::ST_IDLE;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("port active without supply");
  property p_change_low;
    por_s && $past(por_s) && $changed(o_sda_oe) |-> !scl_s;
  endproperty
  a_change_low: assert property (p_change_low) else $error("data moved with clock high");
  property p_start_seen;
    ev_start |=> state == rics_pkg::ST_RX_CTL && cnt == 4'h0;
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("start not taken");
  property p_stop_seen;
    ev_stop && por_s |=> state == rics_pkg::ST_IDLE && !o_sda_oe;
  endproperty
  a_stop_seen: assert property (p_stop_seen) else $error("stop not taken");
  property p_addr_ack;
    s_ctl_hit |=> state == rics_pkg::ST_ACK_CTL && rw == $past(lnk.bit_val);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
  property p_addr_nack;
    s_ctl_miss |=> state == rics_pkg::ST_IGNORE ##1 !o_sda_oe;
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");
  property p_ack_drive;
    s_ack_start |=> o_sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ninth clock not acknowledged");
  property p_reg_select;
    state == rics_pkg::ST_RX_REG && byte_done && rx_byte == `RICS_REG_CORE && por_s &&
    !ev_start && !ev_stop |=> ptr == 2'h1 && state == rics_pkg::ST_ACK_REG;
  endproperty
  a_reg_select: assert property (p_reg_select) else $error("register not selected");
  property p_bad_reg;
    state == rics_pkg::ST_RX_REG && byte_done && !reg_ok && por_s &&
    !ev_start && !ev_stop |=> state == rics_pkg::ST_IGNORE;
  endproperty
  a_bad_reg: assert property (p_bad_reg) else $error("invalid register accepted");
  property p_commit;
    ev_stop && por_s && pend[1] |=> o_core_offset_trip == $past(shadow[1]);
  endproperty
  a_commit: assert property (p_commit) else $error("write not applied at stop");
  property p_por_values;
    !por_s |=> cfg[0] == `RICS_RST_NB && cfg[1] == `RICS_RST_CORE && cfg[2] == `RICS_RST_PS;
  endproperty
  a_por_values: assert property (p_por_values) else $error("reset values lost");

endmodule

// ==== bench/rics_bus_master.sv ====
// Behavioural two-wire bus master clocked by its own link clock
`timescale 1ns/10ps
module rics_bus_master (
  input  wire logic i_lnk_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Bus idles with both lines high
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // Quarter bit time; far slower than the system clock
  task automatic q();
    repeat (8) @(posedge i_lnk_clk);
  endtask

  // Data falls while clock high, then clock low
  task automatic start();
    o_sda_low <= 1'b1;
    q();
    o_scl <= 1'b0;
    q();
  endtask

  // Data rises while clock high; clock then stays high
  task automatic stop();
    o_sda_low <= 1'b1;
    q();
    o_scl <= 1'b1;
    q();
    o_sda_low <= 1'b0;
    q();
  endtask

  // Data set while clock low, held through the high phase
  task automatic bit_out(input logic b);
    o_sda_low <= ~b;
    q();
    o_scl <= 1'b1;
    q();
    q();
    o_scl <= 1'b0;
    q();
  endtask

  // Line released so the device may pull it low
  task automatic bit_in(output logic v);
    o_sda_low <= 1'b0;
    q();
    o_scl <= 1'b1;
    q();
    v = i_sda;
    q();
    o_scl <= 1'b0;
    q();
  endtask

  // Eight bits MSB first, ninth clock for the answer
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    bit_in(a);
    ack = ~a;
  endtask

  // Master acknowledges to walk on, or not to end the read
  task automatic rd_byte(output logic [7:0] d, input logic mack);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(~mack);
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the regulator configuration serial slave
`timescale 1ns/10ps
module testbench;
  logic               sys_clk;
  logic               lnk_clk;
  logic               arst_n;
  logic               por_ok;
  logic               scl;
  logic               m_low;
  wire                sda;
  logic               sda_out;
  logic               sda_oe;
  logic [7:0]         nb;
  logic [7:0]         core;
  logic [7:0]         ps;
  logic               nb_ov;
  logic               nb_pg;
  logic               core_ov;
  logic               core_pg;
  logic signed [10:0] nb_mv;
  logic signed [10:0] core_mv;
  logic [1:0]         ph;
  logic [1:0]         shed;
  logic [1:0]         rest;
  logic               keep;
  logic [7:0]         rd;
  logic               ack;
  int                 n_mismatch;
  int                 samples_checked;

  // Wired-AND line with pull-up; either party can only pull low
  assign sda = (sda_oe ? sda_out : 1'b1) & ~m_low;

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Link clock of the master, phase unrelated to the system clock
  initial begin
    lnk_clk = 1'b0;
    #1.3;
    forever #3 lnk_clk = ~lnk_clk;
  end

  rics_bus_master i_rics_bus_master (
    .i_lnk_clk (lnk_clk),
    .i_sda     (sda),
    .o_scl     (scl),
    .o_sda_low (m_low)
  );

  rics_cfg_slave i_rics_cfg_slave (
    .i_sys_clk                      (sys_clk),
    .i_arst_n                       (arst_n),
    .i_scl_clk                      (scl),
    .i_sda_in                       (sda),
    .o_sda_out                      (sda_out),
    .o_sda_oe                       (sda_oe),
    .i_por_ok                       (por_ok),
    .o_north_bridge_offset_trip     (nb),
    .o_core_offset_trip             (core),
    .o_power_savings_options        (ps),
    .o_nb_overvoltage_trip_boost    (nb_ov),
    .o_nb_power_good_output_boost   (nb_pg),
    .o_core_overvoltage_trip_boost  (core_ov),
    .o_core_power_good_output_boost (core_pg),
    .o_nb_offset_mv                 (nb_mv),
    .o_core_offset_mv               (core_mv),
    .o_ps_phase_count               (ph),
    .o_ps_shed_cycles               (shed),
    .o_ps_restore_cycles            (rest),
    .o_ps_core_offset_keep          (keep)
  );

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One byte from the master, answer compared
  task automatic wb(input logic [7:0] b, input logic exp_ack);
    i_rics_bus_master.wr_byte(b, ack);
    chk({10'h000, ack}, {10'h000, exp_ack});
  endtask

  task automatic rb(input logic mack, input logic [7:0] exp);
    i_rics_bus_master.rd_byte(rd, mack);
    chk({3'h0, rd}, {3'h0, exp});
  endtask

  // Margin for synchronisers and the register update
  task automatic settle();
    repeat (12) @(posedge sys_clk);
  endtask

  task automatic regs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    chk({3'h0, nb}, {3'h0, a});
    chk({3'h0, core}, {3'h0, b});
    chk({3'h0, ps}, {3'h0, c});
  endtask

  task automatic final_report();
    $display("TB: mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    $display("[FAIL] %0t watchdog expired", $time);
    n_mismatch++;
    final_report();
  end

  initial begin
    arst_n = 1'b0;
    por_ok = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    por_ok <= 1'b1;
    settle();
    regs(8'h00, 8'h00, 8'h01);
    chk(nb_mv, 11'h000);
    chk({10'h000, sda_out}, 11'h000);
    // Foreign address is left unanswered
    i_rics_bus_master.start();
    wb(8'h8e, 1'b0);
    i_rics_bus_master.stop();
    // Single write, staged until the stop
    i_rics_bus_master.start();
    wb(8'h8c, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h85, 1'b1);
    settle();
    chk({3'h0, core}, 11'h000);
    i_rics_bus_master.stop();
    settle();
    chk({3'h0, core}, 11'h085);
    chk({10'h000, core_ov}, 11'h001);
    chk({10'h000, core_pg}, 11'h000);
    chk(core_mv, 11'h07d);
    // Burst over all three registers, fourth byte refused
    i_rics_bus_master.start();
    wb(8'h8c, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'hc3, 1'b1);
    wb(8'hbf, 1'b1);
    wb(8'h6d, 1'b1);
    wb(8'h55, 1'b0);
    i_rics_bus_master.stop();
    settle();
    regs(8'hc3, 8'hbf, 8'h6d);
    chk({9'h000, nb_ov, nb_pg}, 11'h003);
    chk(nb_mv, 11'h04b);
    chk(core_mv, 11'h7e7);
    chk({3'h0, keep, rest, shed, ph}, 11'h06d);
    // Register address past the map
    i_rics_bus_master.start();
    wb(8'h8c, 1'b1);
    wb(8'h03, 1'b0);
    i_rics_bus_master.stop();
    // Select the first register, then read all three
    i_rics_bus_master.start();
    wb(8'h8c, 1'b1);
    wb(8'h00, 1'b1);
    i_rics_bus_master.stop();
    i_rics_bus_master.start();
    wb(8'h8d, 1'b1);
    rb(1'b1, 8'hc3);
    rb(1'b1, 8'hbf);
    rb(1'b0, 8'h6d);
    i_rics_bus_master.stop();
    // Supply loss clears the registers and silences the port
    @(posedge sys_clk);
    por_ok <= 1'b0;
    settle();
    regs(8'h00, 8'h00, 8'h01);
    i_rics_bus_master.start();
    wb(8'h8c, 1'b0);
    i_rics_bus_master.stop();
    @(posedge sys_clk);
    por_ok <= 1'b1;
    settle();
    i_rics_bus_master.start();
    wb(8'h8c, 1'b1);
    i_rics_bus_master.stop();
    final_report();
  end
endmodule
